// ---- logic/smfe_encoder.sv ----
// Purpose: Serial measurement frame encoder, video frame then tagged values
// Assumes: Pixel and measurement sources answer combinationally to the index outputs
// Notes:   One output cycle per cycle_start pulse accepted while idle
//
// Behaviour
// - 512 pixels per selected signal, clamped 16383
// - Values only follow a video frame
// - Three six-bit bytes with tags 00,01,10/11
// - Codes above 262072 mean errors only
// - Scaling underflow gives 262073
// - Scaling overflow gives 262074
// - Baud overload gives 262075
// - Overload compares bytes demanded against budget
// - Peak before range gives 262077
// - Peak behind range gives 262078
// - Uncomputable value gives 262079
// - Mid of measuring_span encodes as 131000
// - Over 32 values refused with error
// - Unselected values are omitted entirely
`timescale 1ns/1ps
module smfe_encoder (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                cycle_start,
   input  wire logic [2:0]          vid_select,
   input  wire logic [5:0]          val_count,
   input  wire logic [15:0]         byte_budget,
   input  wire logic [15:0]         pix_word,
   input  wire smfe_pkg::smfe_meas_s meas,
   input  wire logic                tx_ready,
   output smfe_pkg::smfe_tx_s       tx,
   output logic [1:0]               pix_sig,
   output logic [8:0]               pix_index,
   output logic [4:0]               val_index,
   output logic                     busy,
   output logic                     too_many_values_error,
   output logic                     overload
);
   import smfe_pkg::*;

   typedef struct packed {
      smfe_state_e st;
      logic [11:0] cnt;
      logic [1:0]  sig;
      logic [2:0]  mask;
      logic [4:0]  vidx;
      logic [5:0]  nval;
      logic [15:0] size;
      logic        over;
      logic        too_many;
      logic        busy;
      smfe_tx_s    tx;
   } smfe_q_s;

   smfe_q_s     q;
   smfe_q_s     next_q;
   logic        rst_meta;
   logic        rst_n;
   logic        step;
   logic [7:0]  cur_byte;
   logic [15:0] pix_lim;
   logic [19:0] lin_sum;
   logic [17:0] code;
   logic [15:0] demand;
   logic [1:0]  nvid;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   // Two stages so the release never lands near a clock edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // First selected video signal at or above a given index
   function automatic logic [2:0] first_sig(input logic [2:0] m, input logic [1:0] from);
      logic [2:0] r;
      r = 3'b100;
      for (int i = 2; i >= 0; i--) begin
         if (m[i] && (2'(i) >= from)) begin
            r = {1'b0, 2'(i)};
         end
      end
      return r;
   endfunction : first_sig

   // ---------------------------------------------------------------
   // Value encoding
   // ---------------------------------------------------------------
   // Linear code: offset plus position, so half a span lands on the mid code
   always_comb begin
      lin_sum = LIN_OFFSET + 20'(meas.frac);
      code    = lin_sum[17:0];
      if (q.over) begin
         code = CODE_BAUD;
      end else begin
         unique case (meas.stat)
            SMFE_NOPEAK: code = CODE_NOPEAK;
            SMFE_BEFORE: code = CODE_BEFORE;
            SMFE_BEHIND: code = CODE_BEHIND;
            SMFE_NOCALC: code = CODE_NOCALC;
            SMFE_OK: begin
               if (lin_sum[19]) begin
                  code = CODE_UNDER;
               end else if (lin_sum > {2'b00, CODE_MAX}) begin
                  code = CODE_OVER;  // Above valid range gives the overflow code
               end
            end
            default: code = CODE_NOCALC;
         endcase
      end
   end

   // Bytes one cycle will demand of the link
   always_comb begin
      nvid   = 2'(vid_select[0]) + 2'(vid_select[1]) + 2'(vid_select[2]);
      demand = FRAME_BYTES + 16'(nvid) * SIG_BYTES + 16'(val_count) * VAL_BYTES;
   end

   // ---------------------------------------------------------------
   // Byte selection per state
   // ---------------------------------------------------------------
   always_comb begin
      pix_lim  = (pix_word > PIX_MAX) ? PIX_MAX : pix_word;
      cur_byte = 8'h00;
      unique case (q.st)
         ST_IDLE: cur_byte = 8'h00;
         ST_PRE:  cur_byte = 8'(START_MARK >> (8 * (7 - int'(q.cnt))));
         ST_SIZE: cur_byte = 8'({16'h0000, q.size} >> (8 * (3 - int'(q.cnt))));
         ST_PIX:  cur_byte = q.cnt[0] ? pix_lim[7:0] : pix_lim[15:8];
         ST_END:  cur_byte = 8'(END_MARK >> (8 * (3 - int'(q.cnt))));
         ST_VAL: begin
            // Six data bits per byte, tag in the top two
            if (q.cnt == 12'h000) begin
               cur_byte = {TAG_LOW, code[5:0]};
            end else if (q.cnt == 12'h001) begin
               cur_byte = {TAG_MID, code[11:6]};
            end else begin
               cur_byte = {(q.vidx == 5'h00) ? TAG_HIGH1 : TAG_HIGHN, code[17:12]};
            end
         end
         default: cur_byte = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // A byte moves on only when the output slot is free or being taken
   always_comb begin
      logic [2:0] nxt;
      logic [2:0] fst;
      // Signal 2 is the last one; a wrapped index would restart the video
      nxt    = (q.sig == 2'h2) ? 3'b100 : first_sig(q.mask, 2'(q.sig + 2'h1));
      fst    = first_sig(q.mask, 2'h0);
      next_q = q;
      step   = (q.st != ST_IDLE) && (!q.tx.valid || tx_ready);
      if (q.tx.valid && tx_ready) begin
         next_q.tx.valid = 1'b0;
      end
      if (step) begin
         next_q.tx.data  = cur_byte;
         next_q.tx.valid = 1'b1;
         next_q.cnt      = q.cnt + 12'h001;
      end
      unique case (q.st)
         ST_IDLE: begin
            if (cycle_start) begin
               if (val_count > MAX_VALUES) begin
                  next_q.too_many = 1'b1;  // Selection refused
               end else begin
                  next_q.too_many = 1'b0;
                  next_q.st       = ST_PRE;
                  next_q.cnt      = 12'h000;
                  next_q.mask     = vid_select;
                  next_q.nval     = val_count;
                  next_q.vidx     = 5'h00;
                  next_q.size     = 16'(nvid) * SIG_BYTES;
                  next_q.over     = demand > byte_budget;
               end
            end
         end
         ST_PRE: begin
            if (step && q.cnt == START_LAST) begin
               next_q.st  = ST_SIZE;
               next_q.cnt = 12'h000;
            end
         end
         ST_SIZE: begin
            if (step && q.cnt == WORD32_LAST) begin
               next_q.cnt = 12'h000;
               next_q.sig = fst[1:0];
               next_q.st  = (q.mask == 3'b000) ? ST_END : ST_PIX;
            end
         end
         ST_PIX: begin
            if (step && q.cnt == PIX_LAST) begin
               next_q.cnt = 12'h000;
               if (nxt[2]) begin
                  next_q.st = ST_END;
               end else begin
                  next_q.sig = nxt[1:0];
               end
            end
         end
         ST_END: begin
            // Values never precede the frame
            if (step && q.cnt == WORD32_LAST) begin
               next_q.cnt = 12'h000;
               next_q.st  = (q.nval == 6'h00) ? ST_IDLE : ST_VAL;
            end
         end
         ST_VAL: begin
            if (step && q.cnt == VAL_LAST) begin
               next_q.cnt  = 12'h000;
               next_q.vidx = q.vidx + 5'h01;
               if ({1'b0, q.vidx} == 6'(q.nval - 6'h01)) begin
                  next_q.st = ST_IDLE;
               end
            end
         end
         default: next_q.st = ST_IDLE;
      endcase
      // Busy kept as its own flop so the pin needs no decode
      next_q.busy = (next_q.st != ST_IDLE);
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Outputs are plain state bits
   assign tx                    = q.tx;
   assign pix_sig               = q.sig;
   assign pix_index             = q.cnt[9:1];
   assign val_index             = q.vidx;
   assign busy                  = q.busy;
   assign too_many_values_error = q.too_many;
   assign overload              = q.over;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_end_done;
      q.st == ST_END && step && q.cnt == WORD32_LAST && q.nval != 6'h00;
   endsequence
   sequence s_first_low;
      q.st == ST_VAL && q.vidx == 5'h00 && q.cnt == 12'h000;
   endsequence

   chk_start_byte: assert property ((q.st == ST_PRE && step && q.cnt == 12'h002) |=> tx.data == 8'h00)
      else $error("start marker byte wrong");
   chk_end_byte: assert property ((q.st == ST_END && step && q.cnt == 12'h000) |=> tx.data == 8'hFE)
      else $error("end marker byte wrong");
   chk_pix_clamp: assert property ((q.st == ST_PIX && step && !q.cnt[0]) |=> tx.data[7:6] == 2'b00)
      else $error("pixel above limit");
   chk_val_order: assert property (s_end_done |=> s_first_low)
      else $error("values did not follow frame");
   chk_val_entry: assert property ((q.st == ST_VAL && $past(q.st) != ST_VAL) |-> $past(q.st) == ST_END)
      else $error("values entered without frame");
   chk_tag_high: assert property ((q.st == ST_VAL && step && q.cnt == VAL_LAST)
      |=> tx.data[7:6] == (($past(q.vidx) == 5'h00) ? TAG_HIGH1 : TAG_HIGHN))
      else $error("high byte tag wrong");
   chk_tag_mid: assert property ((q.st == ST_VAL && step && q.cnt == 12'h001) |=> tx.data[7:6] == TAG_MID)
      else $error("mid byte tag wrong");
   chk_overload_code: assert property ((q.over && q.st == ST_VAL && step && q.cnt == 12'h000)
      |=> tx.data == {TAG_LOW, CODE_BAUD[5:0]})
      else $error("overload code missing");
   chk_valid_range: assert property ((!q.over && meas.stat == SMFE_OK && !lin_sum[19]
      && lin_sum <= {2'b00, CODE_MAX}) |-> code <= CODE_MAX)
      else $error("valid value in error range");
   chk_mid_code: assert property ((!q.over && meas.stat == SMFE_OK && meas.frac == 19'sh08000) |-> code == CODE_MID)
      else $error("mid range code wrong");
   chk_refuse_sel: assert property ((q.st == ST_IDLE && cycle_start && val_count > MAX_VALUES)
      |=> too_many_values_error && q.st == ST_IDLE)
      else $error("oversize selection accepted");
   chk_tx_hold: assert property ((tx.valid && !tx_ready) |=> tx.valid && $stable(tx.data))
      else $error("byte dropped under stall");
endmodule : smfe_encoder

// ---- logic/smfe_pkg.sv ----
// Purpose: Shared constants and types for the serial measurement frame encoder
// Assumes: 18-bit output words, byte-wide serial link behind a ready/valid port
// Notes:   Markers and the size field are sent most significant byte first, codes least significant byte first
package smfe_pkg;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam logic [63:0] START_MARK   = 64'hFFFF00FFFF000000;
   localparam logic [31:0] END_MARK     = 32'hFEFE0000;
   localparam logic [11:0] START_LAST   = 12'h007;  // 8 marker bytes
   localparam logic [11:0] WORD32_LAST  = 12'h003;  // 4 bytes of size or end marker
   localparam logic [11:0] PIX_LAST     = 12'h3FF;  // 512 pixels of 2 bytes
   localparam logic [11:0] VAL_LAST     = 12'h002;  // 3 bytes per value
   localparam logic [15:0] PIX_MAX      = 16'h3FFF;
   localparam logic [15:0] SIG_BYTES    = 16'h0400;  // Payload bytes per video signal
   localparam logic [15:0] FRAME_BYTES  = 16'h0010;  // Markers plus size field
   localparam logic [15:0] VAL_BYTES    = 16'h0003;
   localparam logic [5:0]  MAX_VALUES   = 6'h20;
   // ---------------------------------------------------------------
   // Byte tags and output codes
   // ---------------------------------------------------------------
   localparam logic [1:0]  TAG_LOW      = 2'h0;
   localparam logic [1:0]  TAG_MID      = 2'h1;
   localparam logic [1:0]  TAG_HIGH1    = 2'h2;
   localparam logic [1:0]  TAG_HIGHN    = 2'h3;
   localparam logic [19:0] LIN_OFFSET   = 20'h17FB8;  // 98232
   localparam logic [17:0] CODE_MID     = 18'h1FFB8;  // 131000
   localparam logic [17:0] CODE_MAX     = 18'h3FFB8;  // 262072
   localparam logic [17:0] CODE_UNDER   = 18'h3FFB9;
   localparam logic [17:0] CODE_OVER    = 18'h3FFBA;
   localparam logic [17:0] CODE_BAUD    = 18'h3FFBB;
   localparam logic [17:0] CODE_NOPEAK  = 18'h3FFBC;
   localparam logic [17:0] CODE_BEFORE  = 18'h3FFBD;
   localparam logic [17:0] CODE_BEHIND  = 18'h3FFBE;
   localparam logic [17:0] CODE_NOCALC  = 18'h3FFBF;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SMFE_OK     = 3'b000,
      SMFE_NOPEAK = 3'b001,
      SMFE_BEFORE = 3'b010,
      SMFE_BEHIND = 3'b011,
      SMFE_NOCALC = 3'b100
   } smfe_stat_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE  = 3'b001,
      ST_SIZE = 3'b010,
      ST_PIX  = 3'b011,
      ST_END  = 3'b100,
      ST_VAL  = 3'b101
   } smfe_state_e;
   // Measurement: status plus position, 65536 steps per measuring_span
   typedef struct packed {
      smfe_stat_e         stat;
      logic signed [18:0] frac;
   } smfe_meas_s;
   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } smfe_tx_s;
endpackage : smfe_pkg

// ---- test/smfe_host.sv ----
// Purpose: Host model that takes the encoder byte stream
// Assumes: A byte is taken at an edge with valid and ready both high
// Notes:   Stall mode lowers ready three cycles in four
`timescale 1ns/1ps
module smfe_host #(
   parameter real SPAN_MM = 10.0  // Arbitrary measuring_span
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          stall,
   input  wire smfe_pkg::smfe_tx_s tx,
   output logic               tx_ready
);
   import smfe_pkg::*;
   logic [7:0] rx_q [$];
   logic [1:0] phase = 2'h0;
   // ---------------------------------------------------------------
   // Receive side
   // ---------------------------------------------------------------
   // Ready moves half a cycle from the sampling edge, so it is settled
   always @(negedge ref_clk) begin
      phase <= phase + 2'h1;
      tx_ready <= !stall || (phase == 2'h3);
   end
   // Collect every byte handed over
   always @(posedge ref_clk) begin
      if (nrst && tx.valid && tx_ready) begin
         rx_q.push_back(tx.data);
      end
   end
   // Code to millimetres, mid code gives half a span
   function automatic real to_mm(input int code);
      return (code - 98232) * SPAN_MM / 65536.0;
   endfunction : to_mm
endmodule : smfe_host

// ---- test/smfe_encoder_bench.sv ----
// Purpose: Self-checking bench for the serial measurement frame encoder
// Assumes: Sources answer combinationally to the index outputs
// Notes:   Expected streams are built from the package constants
`timescale 1ns/1ps
module smfe_encoder_bench;
   import smfe_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst;
   logic        cycle_start;
   logic        stall;
   logic        tx_ready;
   logic [2:0]  vid_select;
   logic [5:0]  val_count;
   logic [15:0] byte_budget;
   logic [15:0] pix_word;
   smfe_meas_s  meas;
   smfe_meas_s  meas_tab [0:31];
   smfe_tx_s    tx;
   logic [1:0]  pix_sig;
   logic [8:0]  pix_index;
   logic [4:0]  val_index;
   logic        busy;
   logic        too_many_values_error;
   logic        overload;
   logic [7:0]  exp_q [$];
   int          mismatches = 0;
   int          n_checks = 0;
   // ---------------------------------------------------------------
   // Clock, sources and instances
   // ---------------------------------------------------------------
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Upper pixel bits from the signal index make signals 1 and 2 clamp
   assign pix_word = {pix_sig, 5'h00, pix_index};
   assign meas = meas_tab[val_index];
   smfe_encoder dut (.ref_clk(ref_clk), .nrst(nrst), .cycle_start(cycle_start), .vid_select(vid_select),
      .val_count(val_count), .byte_budget(byte_budget), .pix_word(pix_word), .meas(meas), .tx_ready(tx_ready),
      .tx(tx), .pix_sig(pix_sig), .pix_index(pix_index), .val_index(val_index), .busy(busy),
      .too_many_values_error(too_many_values_error), .overload(overload));
   smfe_host host (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .tx(tx), .tx_ready(tx_ready));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask : chk
   task close_out;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   function automatic smfe_meas_s mk(input smfe_stat_e s, input int f);
      return '{s, 19'(f)};
   endfunction : mk
   // Output code the link must carry for one measurement
   function automatic int code_of(input smfe_meas_s m, input logic over);
      int sum;
      sum = 98232 + int'(m.frac);
      if (over) return 262075;
      if (m.stat == SMFE_NOPEAK) return 262076;
      if (m.stat == SMFE_BEFORE) return 262077;
      if (m.stat == SMFE_BEHIND) return 262078;
      if (m.stat == SMFE_NOCALC) return 262079;
      if (sum < 0) return 262073;
      if (sum > 262072) return 262074;
      return sum;
   endfunction : code_of
   // Whole byte stream of one output cycle
   task automatic expect_frame(input logic [2:0] sel, input int n, input logic over);
      logic [15:0] w;
      logic [17:0] c;
      int          ns;
      exp_q.delete();
      ns = sel[0] + sel[1] + sel[2];
      for (int i = 7; i >= 0; i--) exp_q.push_back(START_MARK[i*8+:8]);
      for (int i = 3; i >= 0; i--) exp_q.push_back(8'((ns * 1024) >> (i * 8)));
      for (int s = 0; s < 3; s++) begin
         for (int p = 0; p < 512 && sel[s]; p++) begin
            w = {2'(s), 5'h00, 9'(p)};
            if (w > PIX_MAX) w = PIX_MAX;
            exp_q.push_back(w[15:8]);
            exp_q.push_back(w[7:0]);
         end
      end
      for (int i = 3; i >= 0; i--) exp_q.push_back(END_MARK[i*8+:8]);
      for (int v = 0; v < n; v++) begin
         c = 18'(code_of(meas_tab[v], over));
         exp_q.push_back({TAG_LOW, c[5:0]});
         exp_q.push_back({TAG_MID, c[11:6]});
         exp_q.push_back({(v == 0) ? TAG_HIGH1 : TAG_HIGHN, c[17:12]});
      end
   endtask : expect_frame
   // One accepted cycle, judged byte by byte
   task automatic run_cycle(input logic [2:0] sel, input logic [5:0] n, input logic [15:0] b, input logic over);
      int k;
      expect_frame(sel, n, over);
      host.rx_q.delete();
      @(negedge ref_clk);
      {vid_select, val_count, byte_budget, cycle_start} = {sel, n, b, 1'b1};
      @(negedge ref_clk);
      cycle_start = 1'b0;
      @(negedge ref_clk);
      chk(busy === 1'b1, "busy not raised");
      chk(too_many_values_error === 1'b0, "error flag not cleared");
      for (k = 0; host.rx_q.size() < exp_q.size() && k < 20000; k++) @(negedge ref_clk);
      if (k == 20000) begin
         chk(1'b0, "frame timeout");
         close_out();
      end
      repeat (8) @(negedge ref_clk);
      chk(host.rx_q.size() == exp_q.size(), "byte count");
      for (int i = 0; i < exp_q.size() && i < host.rx_q.size(); i++) chk(host.rx_q[i] === exp_q[i], "byte");
      chk(overload === over, "overload flag");
      chk(busy === 1'b0, "busy stuck");
   endtask : run_cycle
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Thirty-three values are refused and nothing is sent
   task s_refuse;
      @(negedge ref_clk);
      {val_count, cycle_start} = {6'h21, 1'b1};
      @(negedge ref_clk);
      cycle_start = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk(too_many_values_error === 1'b1, "refusal not flagged");
      chk(busy === 1'b0 && host.rx_q.size() == 0, "refused cycle ran");
   endtask : s_refuse
   // Two signals, mid code, both scaling faults, no peak, stalling host
   task s_mixed;
      logic [17:0] c;
      meas_tab[0] = mk(SMFE_OK, 32768);
      meas_tab[1] = mk(SMFE_OK, -100000);
      meas_tab[2] = mk(SMFE_OK, 200000);
      meas_tab[3] = mk(SMFE_NOPEAK, 0);
      stall = 1'b1;
      run_cycle(3'h5, 6'h04, 16'hFFFF, 1'b0);
      stall = 1'b0;
      // First value follows 12 header bytes, 2048 pixel bytes and the end mark
      c = {host.rx_q[2066][5:0], host.rx_q[2065][5:0], host.rx_q[2064][5:0]};
      chk(host.to_mm(c) == host.SPAN_MM / 2.0, "millimetre decode");
   endtask : s_mixed
   // Thirty-two values, every status, top valid code and zero
   task s_full;
      for (int v = 0; v < 32; v++) meas_tab[v] = mk(smfe_stat_e'(v % 5), (v == 0) ? 163840 : v * 3 - 98247);
      run_cycle(3'h2, 6'h20, 16'hFFFF, 1'b0);
   endtask : s_full
   // Demand 3094 bytes: a budget of 3094 fits, 3093 overloads
   task s_budget;
      for (int b = 0; b < 2; b++) run_cycle(3'h7, 6'h02, 16'(3094 - b), b[0]);
   endtask : s_budget
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {nrst, cycle_start, stall, vid_select, val_count, byte_budget} = {3'h0, 3'h0, 6'h00, 16'hFFFF};
      for (int v = 0; v < 32; v++) meas_tab[v] = mk(SMFE_OK, 0);
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      s_refuse();
      s_mixed();
      s_full();
      s_budget();
      close_out();
   end
endmodule : smfe_encoder_bench
